// [hw/svd_defines.svh]
// register offsets, field positions, reset values and timing counts
// of the supply-voltage detect block; included by bare name.
`ifndef SVD_DEFINES_SVH
`define SVD_DEFINES_SVH

// ----------------------------------------------------------------
// bus shape
// ----------------------------------------------------------------
`define SVD_ADDR_W 8
`define SVD_DATA_W 8

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SVD_CTRL_ADDR 8'h0C
`define SVD_STAT_ADDR 8'h0D
`define SVD_CLR_ADDR 8'h0E
`define SVD_MASK_ADDR 8'h0F

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SVD_EN_BIT 0
`define SVD_LOW_BIT 1
`define SVD_HIGH_BIT 2
`define SVD_EV_READY_BIT 0
`define SVD_EV_LOW_BIT 5
`define SVD_EV_USED 8'h21

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SVD_CTRL_RST 8'h00
`define SVD_STAT_RST 8'h00
`define SVD_MASK_RST 8'h00
`define SVD_RDATA_RST 8'h00

// ----------------------------------------------------------------
// timing: settling delay after enable
// ----------------------------------------------------------------
`define SVD_SETTLE_US 20
`define SVD_CLK_MHZ 250
`define SVD_SETTLE_CYCLES (`SVD_SETTLE_US * `SVD_CLK_MHZ)
`define SVD_CNT_W 13

`endif

// [hw/svd_detect.sv]
// supply-voltage detect control, flags and interrupt request.
// assumes comparator outputs arrive asynchronously from the analog
// macro and that the register master follows the strobe protocol.
// usage rules that bind software are kept by software, not here.
//
// Functional notes
// - detection runs only while the enable bit of the control register is one.
// - the enable bit resets to zero, so detection starts disabled.
// - both flags are valid only 20 us after enable; readers ignore them before.
// - the high flag reads one only while the supply is above the high threshold.
// - the low flag reads one only while the supply is below the low threshold.
// - with detection enabled, a low flag sets interrupt request 5.
// - request 5 stays latched until software clears it or reset comes.
// - request 5 interrupts only when its mask bit is set, else it is a flag.
// - control bits 7 to 3 are reserved, and the flags are read-only, reset 0.
`timescale 1ns/1ps
`default_nettype none
`include "svd_defines.svh"

module svd_detect #(
  parameter int unsigned SETTLE_CYCLES = `SVD_SETTLE_CYCLES
) (
  // clock, reset, freeze
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // register port
  input wire svd_pkg::svd_addr_t regAddr,
  input wire svd_pkg::svd_data_t regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output svd_pkg::svd_data_t regRdata,
  // comparator outputs, asynchronous
  input wire logic compLowRaw,
  input wire logic compHighRaw,
  // status and interrupt
  output logic supplyDetectEnable,
  output logic supplyLowFlag,
  output logic supplyHighFlag,
  output logic supplyInterruptRequest,
  output logic irq
);
  import svd_pkg::*;

  // ----------------------------------------------------------------
  // address decode helper
  // ----------------------------------------------------------------
  function automatic logic addrHit(svd_addr_t addr, svd_addr_t target);
    addrHit = (addr == target);
  endfunction : addrHit

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic lowMeta;
  logic lowSync;
  logic highMeta;
  logic highSync;
  logic enable;
  logic next_enable;
  logic next_lowFlag;
  logic next_highFlag;
  svd_data_t status;
  svd_data_t next_status;
  svd_data_t mask;
  svd_data_t next_mask;
  svd_data_t next_rdata;
  svd_data_t setBits;
  svd_data_t clearBits;
  svd_data_t ctrlView;
  svd_data_t readValue;
  logic wrCtrl;
  logic wrClr;
  logic wrMask;
  logic rdAny;
  logic settled;
  logic lowEvent;
  localparam svd_data_t CTRL_RST = `SVD_CTRL_RST;
  localparam svd_count_t SETTLE_END = `SVD_CNT_W'(SETTLE_CYCLES + 1);
  svd_count_t enCycles;
  svd_count_t next_enCycles;

  svd_settle_if settle ();

  // ----------------------------------------------------------------
  // comparator synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      lowMeta <= 1'b0;
      lowSync <= 1'b0;
      highMeta <= 1'b0;
      highSync <= 1'b0;
    end else if (ce) begin
      lowMeta <= compLowRaw;
      lowSync <= lowMeta;
      highMeta <= compHighRaw;
      highSync <= highMeta;
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign wrCtrl = ce && regWrite && addrHit(regAddr, `SVD_CTRL_ADDR);
  assign wrClr = ce && regWrite && addrHit(regAddr, `SVD_CLR_ADDR);
  assign wrMask = ce && regWrite && addrHit(regAddr, `SVD_MASK_ADDR);
  assign rdAny = ce && regRead;

  // ----------------------------------------------------------------
  // enable bit
  // ----------------------------------------------------------------
  // only bit 0 is stored; writes to bits 7..3 and the flags are lost
  assign next_enable = wrCtrl ? regWdata[`SVD_EN_BIT] : enable;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      enable <= CTRL_RST[`SVD_EN_BIT];
    end else if (ce) begin
      enable <= next_enable;
    end
  end

  assign supplyDetectEnable = enable;

  // ----------------------------------------------------------------
  // settle timer
  // ----------------------------------------------------------------
  assign settle.ce = ce;
  assign settle.run = enable;
  assign settled = settle.ready;

  svd_settle_timer #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) svd_settle_timer_inst (
    .core_clk(core_clk),
    .rstn(rstn),
    .tmr(settle)
  );

  // ----------------------------------------------------------------
  // supply flags
  // ----------------------------------------------------------------
  // flags stay low until the comparators have settled
  assign next_highFlag = settled && highSync;
  assign next_lowFlag = settled && lowSync;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      supplyHighFlag <= 1'b0;
      supplyLowFlag <= 1'b0;
    end else if (ce) begin
      supplyHighFlag <= next_highFlag;
      supplyLowFlag <= next_lowFlag;
    end
  end

  // ----------------------------------------------------------------
  // event status, clear and mask
  // ----------------------------------------------------------------
  assign lowEvent = enable && settled && lowSync;

  always_comb begin
    setBits = '0;
    setBits[`SVD_EV_LOW_BIT] = lowEvent;
    setBits[`SVD_EV_READY_BIT] = settle.done;
  end

  assign clearBits = wrClr ? (regWdata & `SVD_EV_USED) : '0;
  // a set in the clearing cycle wins, so no event is lost
  assign next_status = (status & ~clearBits) | setBits;
  assign next_mask = wrMask ? (regWdata & `SVD_EV_USED) : mask;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      status <= `SVD_STAT_RST;
      mask <= `SVD_MASK_RST;
    end else if (ce) begin
      status <= next_status;
      mask <= next_mask;
    end
  end

  assign supplyInterruptRequest = status[`SVD_EV_LOW_BIT];
  assign irq = |(status & mask);

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    ctrlView = '0;
    ctrlView[`SVD_EN_BIT] = enable;
    ctrlView[`SVD_LOW_BIT] = supplyLowFlag;
    ctrlView[`SVD_HIGH_BIT] = supplyHighFlag;
  end

  assign readValue =
    addrHit(regAddr, `SVD_CTRL_ADDR) ? ctrlView :
    addrHit(regAddr, `SVD_STAT_ADDR) ? status :
    addrHit(regAddr, `SVD_MASK_ADDR) ? mask : '0;

  // read data stand only in the cycle after the strobe
  assign next_rdata = rdAny ? readValue : `SVD_RDATA_RST;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      regRdata <= `SVD_RDATA_RST;
    end else if (ce) begin
      regRdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // settle delay monitor, read by the checks only
  // ----------------------------------------------------------------
  // counts enabled edges and stops once the delay is over
  assign next_enCycles =
    !enable ? '0 :
    (enCycles == SETTLE_END) ? enCycles : enCycles + 1'b1;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      enCycles <= '0;
    end else if (ce) begin
      enCycles <= next_enCycles;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_enable_write: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wrCtrl |=> (enable == $past(regWdata[`SVD_EN_BIT]))
  ) else $error("enable bit did not follow the control write");

  a_enable_reset: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(rstn) |-> !enable && !supplyLowFlag && !supplyHighFlag
  ) else $error("state not cleared after reset");

  a_flag_settle: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (ce && !settled) |=> !supplyLowFlag && !supplyHighFlag
  ) else $error("flag raised before the settle delay ended");

  a_disable_silent: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (ce && !enable) ##1 ce |=> !supplyLowFlag && !supplyHighFlag
  ) else $error("flag raised while detection disabled");

  a_high_follows: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (ce && settled) |=> (supplyHighFlag == $past(highSync))
  ) else $error("high flag does not follow the comparator");

  a_low_follows: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (ce && settled) |=> (supplyLowFlag == $past(lowSync))
  ) else $error("low flag does not follow the comparator");

  a_request_set: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (ce && enable && settled && lowSync) |=> supplyInterruptRequest
  ) else $error("low supply did not raise request 5");

  a_request_hold: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (supplyInterruptRequest &&
     !(wrClr && regWdata[`SVD_EV_LOW_BIT])) |=> supplyInterruptRequest
  ) else $error("request 5 dropped without a clear");

  a_request_mask: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (supplyInterruptRequest && !mask[`SVD_EV_LOW_BIT] &&
     !status[`SVD_EV_READY_BIT]) |-> !irq
  ) else $error("masked request 5 reached the interrupt line");

  a_reserved_zero: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (rdAny && addrHit(regAddr, `SVD_CTRL_ADDR)) |=>
      (regRdata[7:3] == 5'h00) && (regRdata[0] == $past(enable))
  ) else $error("control read shows reserved bits or wrong enable");

  a_sync_delay: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (ce && settled && $rose(compLowRaw)) ##1 ce |=> !$past(lowMeta) ||
      $past(lowSync, 1) == $past(lowMeta, 2)
  ) else $error("low comparator skipped the synchroniser");

  a_enable_hold: assert property (
    @(posedge core_clk) disable iff (!rstn)
    !wrCtrl |=> $stable(enable)
  ) else $error("enable bit changed without a control write");

  a_disable_idle: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (ce && !enable) |=> !settled
  ) else $error("settle timer kept running while disabled");

  a_settle_time: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(settled) |-> (enCycles == SETTLE_END)
  ) else $error("settle delay has the wrong length");

  a_ready_event: assert property (
    @(posedge core_clk) disable iff (!rstn)
    $rose(settled) |-> status[`SVD_EV_READY_BIT]
  ) else $error("settle-done event not raised");

  a_high_source: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (supplyHighFlag && $past(ce)) |-> $past(highSync) && $past(settled)
  ) else $error("high flag set without a settled high comparator");

  a_low_source: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (supplyLowFlag && $past(ce)) |-> $past(lowSync) && $past(settled)
  ) else $error("low flag set without a settled low comparator");

  a_request_gated: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (ce && !enable && !supplyInterruptRequest) |=> !supplyInterruptRequest
  ) else $error("request 5 set while detection disabled");

  a_request_clear: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (wrClr && regWdata[`SVD_EV_LOW_BIT] && !lowEvent) |=>
      !supplyInterruptRequest
  ) else $error("request 5 survived a clear");

  a_irq_unmasked: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (supplyInterruptRequest && mask[`SVD_EV_LOW_BIT]) |-> irq
  ) else $error("unmasked request 5 did not raise the interrupt");

  a_status_readonly: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (ce && regWrite && addrHit(regAddr, `SVD_STAT_ADDR)) |=>
      (status == ($past(status) | $past(setBits)))
  ) else $error("write changed the read-only status");

  a_mask_write: assert property (
    @(posedge core_clk) disable iff (!rstn)
    wrMask |=> (mask == ($past(regWdata) & `SVD_EV_USED))
  ) else $error("mask did not take the written value");

endmodule : svd_detect

`default_nettype wire

// [hw/svd_pkg.sv]
// types shared by the supply-voltage detect modules.
// assumes svd_defines.svh is on the include path.
`default_nettype none
`include "svd_defines.svh"

package svd_pkg;

  typedef logic [`SVD_ADDR_W-1:0] svd_addr_t;
  typedef logic [`SVD_DATA_W-1:0] svd_data_t;
  typedef logic [`SVD_CNT_W-1:0] svd_count_t;

  typedef enum logic [1:0] {
    SVD_IDLE,
    SVD_SETTLING,
    SVD_READY
  } svd_settle_state_t;

endpackage : svd_pkg

`default_nettype wire

// [hw/svd_settle_if.sv]
// carrier between the detect control logic and its settle timer.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface svd_settle_if;
  logic ce;
  logic run;
  logic ready;
  logic done;

  modport ctrl (output ce, output run, input ready, input done);
  modport timer (input ce, input run, output ready, output done);
endinterface : svd_settle_if

`default_nettype wire

// [hw/svd_settle_timer.sv]
// settle timer: counts the comparator settling delay after enable.
// assumes run is a registered level on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "svd_defines.svh"

module svd_settle_timer #(
  parameter int unsigned SETTLE_CYCLES = `SVD_SETTLE_CYCLES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control side
  svd_settle_if.timer tmr
);
  import svd_pkg::*;

  localparam svd_count_t LAST = `SVD_CNT_W'(SETTLE_CYCLES - 1);

  svd_settle_state_t state;
  svd_settle_state_t next_state;
  svd_count_t count;
  svd_count_t next_count;
  logic atLast;

  assign atLast = (count == LAST);
  assign tmr.ready = (state == SVD_READY);
  assign tmr.done = tmr.ce && (state == SVD_SETTLING) && atLast && tmr.run;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      SVD_IDLE: begin
        next_count = '0;
        if (tmr.run) begin
          next_state = SVD_SETTLING;
        end
      end
      SVD_SETTLING: begin
        next_count = count + 1'b1;
        if (atLast) begin
          next_state = SVD_READY;
        end
      end
      SVD_READY: begin
        next_count = '0;
      end
      default: begin
        next_state = SVD_IDLE;
        next_count = '0;
      end
    endcase
    // disabling restarts the delay from the next enable
    if (!tmr.run) begin
      next_state = SVD_IDLE;
      next_count = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= SVD_IDLE;
      count <= '0;
    end else if (tmr.ce) begin
      state <= next_state;
      count <= next_count;
    end
  end

endmodule : svd_settle_timer

`default_nettype wire

// [verif/tb_svd_detect.sv]
// self-checking bench for the supply-voltage detect block.
// assumes svd_defines.svh on the include path and a 250 MHz core clock.
`timescale 1ns/1ps
`default_nettype none
`include "svd_defines.svh"

module tb_svd_detect;
  import svd_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int unsigned SETTLE = 8;
  logic core_clk;
  logic rstn;
  logic ce;
  logic regWrite;
  logic regRead;
  logic compLowRaw;
  logic compHighRaw;
  svd_addr_t regAddr;
  svd_data_t regWdata;
  svd_data_t regRdata;
  svd_data_t rdv;
  logic supplyDetectEnable;
  logic supplyLowFlag;
  logic supplyHighFlag;
  logic supplyInterruptRequest;
  logic irq;
  logic lo, hi, expReq;
  int n_fail;
  int checks_done;

  svd_detect #(.SETTLE_CYCLES(SETTLE)) svd_detect_inst (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .compLowRaw(compLowRaw),
    .compHighRaw(compHighRaw),
    .supplyDetectEnable(supplyDetectEnable),
    .supplyLowFlag(supplyLowFlag),
    .supplyHighFlag(supplyHighFlag),
    .supplyInterruptRequest(supplyInterruptRequest),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic chk(input svd_data_t seen, input svd_data_t exp,
                     input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s saw %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic tdone(input string name);
    $display("test %s finished, mismatches so far %0d", name, n_fail);
  endtask : tdone

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr(input svd_addr_t a, input svd_data_t d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    #1;
  endtask : wr

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input svd_addr_t a, output svd_data_t d);
    @(posedge core_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  task automatic comp(input logic l, input logic h);
    @(posedge core_clk);
    compLowRaw <= l;
    compHighRaw <= h;
  endtask : comp

  function automatic svd_data_t expCtrl(input logic en, input logic l,
                                        input logic h);
    return {5'h00, h & en, l & en, en};
  endfunction : expCtrl

  function automatic svd_data_t outs();
    return {3'h0, supplyDetectEnable, supplyLowFlag, supplyHighFlag,
            supplyInterruptRequest, irq};
  endfunction : outs

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    conclude();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h1FAE911F));
    n_fail = 0;
    checks_done = 0;
    rstn = 1'b0;
    ce = 1'b1;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    compLowRaw = 1'b0;
    compHighRaw = 1'b0;
    expReq = 1'b0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    #1;
    chk(outs(), 8'h00, "outputs after reset");
    rd(8'h0C, rdv);
    chk(rdv, 8'h00, "control reset");
    rd(8'h0D, rdv);
    chk(rdv, 8'h00, "status reset");
    rd(8'h0F, rdv);
    chk(rdv, 8'h00, "mask reset");
    tick(1);
    chk(regRdata, 8'h00, "read data dropped");
    tdone("reset");
    // enable with both comparators high: flags masked while settling
    comp(1'b1, 1'b1);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, rdv);
    chk(rdv, 8'h01, "control while settling");
    chk({7'h00, supplyInterruptRequest}, 8'h00, "request settling");
    tick(SETTLE + 6);
    rd(8'h0C, rdv);
    chk(rdv, 8'h07, "control settled");
    chk({7'h00, supplyInterruptRequest}, 8'h01, "request set");
    rd(8'h0D, rdv);
    chk(rdv, 8'h21, "status settled");
    chk({7'h00, irq}, 8'h00, "irq masked");
    tdone("settle");
    // supply recovers: request stays, unmask and clear it
    comp(1'b0, 1'b0);
    tick(5);
    rd(8'h0C, rdv);
    chk(rdv, 8'h01, "flags dropped");
    chk({7'h00, supplyInterruptRequest}, 8'h01, "request held");
    wr(8'h0F, 8'hFF);
    rd(8'h0F, rdv);
    chk(rdv, 8'h21, "mask readback");
    wr(8'h0F, 8'h20);
    chk({7'h00, irq}, 8'h01, "irq unmasked");
    wr(8'h0E, 8'h20);
    chk({6'h00, supplyInterruptRequest, irq}, 8'h00, "cleared");
    rd(8'h0D, rdv);
    chk(rdv, 8'h01, "status after clear");
    wr(8'h0E, 8'h01);
    rd(8'h0D, rdv);
    chk(rdv, 8'h00, "event cleared");
    tdone("sticky");
    // refused accesses
    wr(8'h0D, 8'hFF);
    rd(8'h0D, rdv);
    chk(rdv, 8'h00, "status read only");
    rd(8'h55, rdv);
    chk(rdv, 8'h00, "unmapped read");
    @(posedge core_clk);
    ce <= 1'b0;
    wr(8'h0C, 8'h00);
    @(posedge core_clk);
    ce <= 1'b1;
    rd(8'h0C, rdv);
    chk(rdv, 8'h01, "frozen write");
    tdone("refused");
    // random comparator levels while enabled
    for (int i = 0; i < 16; i++) begin
      lo = 1'($urandom);
      hi = 1'($urandom);
      comp(lo, hi);
      tick(5); // levels held while the flags are read
      rd(8'h0C, rdv);
      chk(rdv, expCtrl(1'b1, lo, hi), "random flags");
      expReq = expReq | lo;
      chk({7'h00, supplyInterruptRequest}, {7'h00, expReq}, "rand req");
    end
    tdone("random");
    // disable first so a standing low level cannot re-set the request
    wr(8'h0C, 8'h00);
    wr(8'h0E, 8'h21);
    comp(1'b1, 1'b1);
    tick(5);
    rd(8'h0C, rdv);
    chk(rdv, 8'h00, "disabled control");
    chk(outs(), 8'h00, "disabled outputs");
    wr(8'h0F, 8'h20);
    wr(8'h0C, 8'h01);
    rd(8'h0C, rdv);
    chk(rdv, 8'h01, "restart settling");
    tick(SETTLE + 6);
    rd(8'h0C, rdv);
    chk(rdv, 8'h07, "restart settled");
    chk({7'h00, irq}, 8'h01, "irq at low supply");
    tdone("disable");
    // reset in mid-run clears everything
    @(posedge core_clk);
    rstn <= 1'b0;
    tick(2);
    chk(outs(), 8'h00, "mid-run reset");
    @(posedge core_clk);
    rstn <= 1'b1;
    rd(8'h0C, rdv);
    chk(rdv, 8'h00, "control after reset");
    tdone("reset again");
    conclude();
  end
endmodule : tb_svd_detect

`default_nettype wire
